// [hdl/mdpcc_chain_top.sv]
// Daisy-chain configuration control of one device fed from a shared parallel flash
module mdpcc_chain_top
    import mdpcc_pkg::*;
#(
    parameter int IMAGE_BYTES = IMAGE_BYTES_DEF
) (
    input  wire logic                sys_clk_in,             // System clock, 20 MHz
    input  wire logic                reset_in,               // Synchronous reset, high active
    input  wire logic                config_clock_in,        // Shared configuration clock
    input  wire logic [SCHEME_W-1:0] scheme_select_pins_in,  // Scheme strap pins
    input  wire logic                lane_high_strap_in,     // Slave strap: take high byte lane
    input  wire logic                chain_enable_n_in,      // Chain enable from previous device
    output logic                     chain_enable_n_out,     // Chain enable to next device
    input  wire logic                user_io_enable_in,      // User logic owns chain pin
    input  wire logic                user_io_in,             // User level for chain pin
    input  wire logic                reconfig_request_n_in,  // Shared reconfiguration request
    input  wire logic                config_status_n_in,     // Status line level
    output logic                     config_status_n_out,    // Status drive value
    output logic                     config_status_oe_out,   // Status pull-low enable
    input  wire logic                config_complete_in,     // Complete line level
    output logic                     config_complete_out,    // Complete drive value
    output logic                     config_complete_oe_out, // Complete pull-low enable
    output logic [ADDR_W-1:0]        flash_addr_out,         // Flash word address, link domain
    input  wire logic [DATA_W-1:0]   flash_data_in,          // Data bus level
    output logic [DATA_W-1:0]        flash_data_out,         // Data bus drive value
    output logic                     flash_data_oe_out,      // Data bus drive enable
    output logic                     flash_ce_n_out,         // Flash chip enable, link domain
    output logic                     flash_oe_n_out,         // Flash output enable, link domain
    output logic                     flash_adv_n_out,        // Flash address valid, link domain
    output logic                     flash_we_n_out,         // Flash write enable
    input  wire logic                flash_wait_in,          // Flash wait indication
    output logic                     user_wait_out,          // Wait seen by user logic
    output logic [BYTE_W-1:0]        config_byte_out,        // Captured byte, link domain
    output logic                     config_byte_valid_out,  // Byte strobe, link domain
    output logic                     config_clock_run_out,   // Oscillator onto clock line
    output logic                     init_start_out,         // Initialization start pulse
    output logic                     user_mode_out           // Device in user mode
);

    mdpcc_top_s   cur;
    mdpcc_top_s   nxt;
    mdpcc_xing_if xing ();

    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] sy;
    logic              reconf_low;

    // Every control and strap pin except user_io_enable_in and user_io_in, and the link done level, pass two flops before use
    assign pins = {scheme_select_pins_in,
                   xing.done,
                   lane_high_strap_in,
                   flash_wait_in,
                   config_complete_in,
                   config_status_n_in,
                   reconfig_request_n_in,
                   chain_enable_n_in};

    // Only the second stage is ever read
    assign sy = cur.sync;
    assign reconf_low = !sy[SY_RECONF];

    // Role decode, used only at strap capture, for both the role and the lane choice
    function automatic logic is_active_scheme(input logic [SCHEME_W-1:0] code);
        return code == ACTIVE_PARALLEL_SCHEME;
    endfunction

    // Control sequence
    always_comb begin
        nxt = cur;
        nxt.meta = pins;
        nxt.sync = cur.meta;
        nxt.init_start = 1'b0;
        case (cur.state)
            // Pull status low and hold everything while the request is low
            ST_RESET: begin
                nxt.status_oe = 1'b1;
                nxt.complete_oe = 1'b1;
                nxt.chain_n = 1'b1;
                nxt.run = 1'b0;
                nxt.user_mode = 1'b0;
                nxt.clk_run = 1'b0;
                // Straps are caught here, after reset release, never at reset
                nxt.is_master = is_active_scheme(sy[SY_SCHEME +: SCHEME_W]);
                nxt.lane_high = sy[SY_LANE] && !is_active_scheme(sy[SY_SCHEME +: SCHEME_W]);
                if (!reconf_low) begin
                    nxt.state = ST_WAIT_ENABLE;
                    nxt.status_oe = 1'b0;
                end
            end
            // First device sees a grounded enable and starts at once
            ST_WAIT_ENABLE: begin
                if (!sy[SY_CHAIN]) begin
                    nxt.state = ST_LOAD;
                    nxt.run = 1'b1;
                    nxt.clk_run = cur.is_master;
                end
            end
            // Capture own image; complete line stays pulled low meanwhile
            ST_LOAD: begin
                nxt.complete_oe = 1'b1;
                if (sy[SY_LDONE]) begin
                    nxt.state = ST_RELEASED;
                    nxt.chain_n = 1'b0;
                    nxt.complete_oe = 1'b0;
                end
            end
            // Master keeps the stream running for the devices behind it
            ST_RELEASED: begin
                if (!cur.is_master) begin
                    nxt.run = 1'b0;
                end
                if (sy[SY_CDONE]) begin
                    nxt.state = ST_INIT;
                    nxt.init_start = 1'b1;
                    nxt.run = 1'b0;
                    nxt.clk_run = 1'b0;
                end
            end
            // One cycle of initialization start, then user mode
            ST_INIT: begin
                nxt.state = ST_USER;
                nxt.user_mode = 1'b1;
            end
            // Chain pin may be handed to user logic
            ST_USER: begin
                nxt.chain_n = user_io_enable_in ? user_io_in : 1'b0;
            end
            default: begin
                nxt.state = ST_RESET;
            end
        endcase
        // Another device pulling status low while loading aborts the load
        if ((cur.state == ST_LOAD || cur.state == ST_RELEASED) && !sy[SY_STATUS]) begin
            nxt.state = ST_RESET;
            nxt.run = 1'b0;
        end
        // A reconfiguration request wins over any state
        if (reconf_low) begin
            nxt.state = ST_RESET;
            nxt.run = 1'b0;
            nxt.status_oe = 1'b1;
        end
        // Wait is only passed on in user mode
        nxt.user_wait = nxt.user_mode && sy[SY_WAIT];
    end

    // State register
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            cur <= TOP_RST;
        end else begin
            cur <= nxt;
        end
    end

    // Levels into the link domain; role bits settle before run rises
    assign xing.run = cur.run;
    assign xing.is_master = cur.is_master;
    assign xing.lane_high = cur.lane_high;

    // Byte capture and flash streaming on the configuration clock
    mdpcc_link_capture #(
        .IMAGE_BYTES (IMAGE_BYTES)
    ) u_link (
        .config_clock_in       (config_clock_in),
        .xing                  (xing.link),
        .flash_data_in         (flash_data_in),
        .flash_addr_out        (flash_addr_out),
        .flash_ce_n_out        (flash_ce_n_out),
        .flash_oe_n_out        (flash_oe_n_out),
        .flash_adv_n_out       (flash_adv_n_out),
        .config_byte_out       (config_byte_out),
        .config_byte_valid_out (config_byte_valid_out)
    );

    // Open-drain pins only ever pull low; the high level is external
    assign config_status_n_out = 1'b0;
    assign config_status_oe_out = cur.status_oe;
    assign config_complete_out = 1'b0;
    assign config_complete_oe_out = cur.complete_oe;

    // Flash is read only while configuring, data bus never driven
    assign flash_data_out = 16'h0000;
    assign flash_data_oe_out = 1'b0;
    assign flash_we_n_out = 1'b1;

    // Remaining outputs straight from the state register
    assign chain_enable_n_out = cur.chain_n;
    assign user_wait_out = cur.user_wait;
    assign config_clock_run_out = cur.clk_run;
    assign init_start_out = cur.init_start;
    assign user_mode_out = cur.user_mode;

endmodule // mdpcc_chain_top

// [common/mdpcc_pkg.sv]
// Constants, state encoding and state layout for the configuration chain block
package mdpcc_pkg;

    // Bus widths
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int SCHEME_W = 2;

    // Scheme strap codes (values of the scheme-select pins)
    localparam logic [SCHEME_W-1:0] ACTIVE_PARALLEL_SCHEME = 2'h1;
    localparam logic [SCHEME_W-1:0] PASSIVE_PARALLEL_SLAVE_SCHEME = 2'h2;

    // First flash word address of the configuration image
    localparam logic [ADDR_W-1:0] BOOT_ADDR = 24'h010000;

    // Clocks: master oscillator and system clock
    localparam int OSC_FREQ_MHZ = 40;
    localparam int SYS_CLK_PERIOD_NS = 50;

    // Default image size in bytes per device
    localparam int IMAGE_BYTES_DEF = 1024;

    // Bit positions inside the pin synchroniser vector
    localparam int SY_CHAIN = 0;
    localparam int SY_RECONF = 1;
    localparam int SY_STATUS = 2;
    localparam int SY_CDONE = 3;
    localparam int SY_WAIT = 4;
    localparam int SY_LANE = 5;
    localparam int SY_LDONE = 6;
    localparam int SY_SCHEME = 7;
    localparam int SYNC_W = 9;
    localparam logic [SYNC_W-1:0] SYNC_RST = 9'h000;

    // Control sequence of the device
    typedef enum logic [2:0] {
        ST_RESET       = 3'h0,
        ST_WAIT_ENABLE = 3'h1,
        ST_LOAD        = 3'h2,
        ST_RELEASED    = 3'h3,
        ST_INIT        = 3'h4,
        ST_USER        = 3'h5
    } mdpcc_state_e;

    // All system-domain state of the top module
    typedef struct packed {
        mdpcc_state_e        state;
        logic [SYNC_W-1:0]   meta;
        logic [SYNC_W-1:0]   sync;
        logic                is_master;
        logic                lane_high;
        logic                run;
        logic                chain_n;
        logic                status_oe;
        logic                complete_oe;
        logic                init_start;
        logic                user_mode;
        logic                clk_run;
        logic                user_wait;
    } mdpcc_top_s;

    localparam mdpcc_top_s TOP_RST = '{
        state: ST_RESET, meta: SYNC_RST, sync: SYNC_RST,
        is_master: 1'b0, lane_high: 1'b0, run: 1'b0, chain_n: 1'b1,
        status_oe: 1'b1, complete_oe: 1'b1, init_start: 1'b0,
        user_mode: 1'b0, clk_run: 1'b0, user_wait: 1'b0};

endpackage : mdpcc_pkg

// [common/mdpcc_xing_if.sv]
// Levels passed between the system domain and the link capture domain
interface mdpcc_xing_if;
    logic run;       // Capture window open, system domain level
    logic is_master; // Role, static while run is high
    logic lane_high; // Byte lane choice, static while run is high
    logic done;      // Own image captured, link domain level

    modport sys (output run, output is_master, output lane_high, input done);
    modport link (input run, input is_master, input lane_high, output done);
endinterface : mdpcc_xing_if

// [hdl/mdpcc_link_capture.sv]
// Link-domain flash reader and byte capture on the configuration clock
module mdpcc_link_capture
    import mdpcc_pkg::*;
#(
    parameter int IMAGE_BYTES = IMAGE_BYTES_DEF
) (
    input  wire logic              config_clock_in,   // Shared configuration clock
    mdpcc_xing_if.link             xing,              // Crossing levels
    input  wire logic [DATA_W-1:0] flash_data_in,     // Shared data bus level
    output logic      [ADDR_W-1:0] flash_addr_out,    // Flash word address
    output logic                   flash_ce_n_out,    // Flash chip enable, low active
    output logic                   flash_oe_n_out,    // Flash output enable, low active
    output logic                   flash_adv_n_out,   // Flash address valid, low active
    output logic      [BYTE_W-1:0] config_byte_out,   // Captured byte
    output logic                   config_byte_valid_out // One pulse per captured byte
);

    localparam int CNT_W = $clog2(IMAGE_BYTES + 1);
    localparam logic [CNT_W-1:0] LAST_BYTE = CNT_W'(IMAGE_BYTES - 1);

    // Sizes the logic cannot serve
    if (IMAGE_BYTES < 2) begin : g_bad_size
        $error("IMAGE_BYTES must be at least 2");
    end

    typedef struct packed {
        logic              run_meta;
        logic              run_sync;
        logic [ADDR_W-1:0] addr;
        logic [CNT_W-1:0]  count;
        logic              done;
        logic              ce_n;
        logic              oe_n;
        logic              adv_n;
        logic [BYTE_W-1:0] byte_q;
        logic              valid;
    } mdpcc_link_s;

    mdpcc_link_s cur;
    mdpcc_link_s nxt;

    // Next state; closing the window (run low) clears everything but the captured byte, so the
    // clock may stop between loads without leaving stale state behind
    always_comb begin
        nxt = cur;
        nxt.run_meta = xing.run;
        nxt.run_sync = cur.run_meta;
        nxt.valid = 1'b0;
        if (!cur.run_sync) begin
            nxt.addr = BOOT_ADDR;
            nxt.count = '0;
            nxt.done = 1'b0;
            nxt.ce_n = 1'b1;
            nxt.oe_n = 1'b1;
            nxt.adv_n = 1'b1;
        end else begin
            // Master streams the flash for the whole chain; wait is never looked at
            if (xing.is_master) begin
                nxt.ce_n = 1'b0;
                nxt.oe_n = 1'b0;
                nxt.adv_n = !cur.ce_n;
                if (!cur.adv_n || !cur.ce_n) begin
                    nxt.addr = cur.addr + 24'h000001;
                end
            end
            // One byte per rising edge while enabled, bus ignored once done; the master
            // skips the two edges before the flash answers its first address
            if (!cur.done && (!xing.is_master || (!cur.ce_n && cur.adv_n))) begin
                nxt.byte_q = xing.lane_high ? flash_data_in[15:8] : flash_data_in[7:0];
                nxt.valid = 1'b1;
                nxt.count = cur.count + CNT_W'(1);
                nxt.done = (cur.count == LAST_BYTE);
            end
        end
    end

    // Link-domain register; reset comes through the run window
    always_ff @(posedge config_clock_in) begin
        cur <= nxt;
    end

    assign xing.done = cur.done;
    assign flash_addr_out = cur.addr;
    assign flash_ce_n_out = cur.ce_n;
    assign flash_oe_n_out = cur.oe_n;
    assign flash_adv_n_out = cur.adv_n;
    assign config_byte_out = cur.byte_q;
    assign config_byte_valid_out = cur.valid;

endmodule // mdpcc_link_capture

// [verif/mdpcc_chain_monitor.sv]
// Concurrent checks on the ports of the chain control top
module mdpcc_chain_monitor
    import mdpcc_pkg::*;
(
    input wire logic                sys_clk_in,             // System clock
    input wire logic                reset_in,               // Reset, high
    input wire logic                config_clock_in,        // Link clock
    input wire logic [SCHEME_W-1:0] scheme_select_pins_in,  // Scheme strap
    input wire logic                lane_high_strap_in,     // Lane strap
    input wire logic                chain_enable_n_in,      // Chain enable in
    input wire logic                chain_enable_n_out,     // Chain enable out
    input wire logic                config_complete_in,     // Complete line level
    input wire logic                config_complete_out,    // Complete drive value
    input wire logic                config_complete_oe_out, // Complete pull-low
    input wire logic                config_status_n_out,    // Status drive value
    input wire logic                init_start_out,         // Init pulse
    input wire logic                user_mode_out,          // User mode
    input wire logic                user_wait_out,          // Wait seen by user
    input wire logic [DATA_W-1:0]   flash_data_in,          // Data bus
    input wire logic [ADDR_W-1:0]   flash_addr_out,         // Flash address
    input wire logic                flash_ce_n_out,         // Flash chip enable
    input wire logic                flash_adv_n_out,        // Flash address valid
    input wire logic [BYTE_W-1:0]   config_byte_out,        // Captured byte
    input wire logic                config_byte_valid_out   // Byte strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    // Lane this device should read; the master always takes the low byte
    logic hi_lane;
    assign hi_lane = (scheme_select_pins_in != ACTIVE_PARALLEL_SCHEME) && lane_high_strap_in;

    release_on_enable_a:
    assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !chain_enable_n_out && !user_mode_out |-> !config_complete_oe_out) else $error("complete still held");
    hold_until_loaded_a:
    assert property (@(posedge sys_clk_in) disable iff (reset_in)
        chain_enable_n_out && !user_mode_out |-> config_complete_oe_out) else $error("complete released early");
    init_together_a:
    assert property (@(posedge sys_clk_in) disable iff (reset_in) $rose(init_start_out) |->
        $past(config_complete_in, 2) ##1 (!init_start_out && user_mode_out)) else $error("init start wrong");
    wait_ignored_a:
    assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !user_mode_out && !$past(user_mode_out) |-> !user_wait_out) else $error("wait seen while loading");
    open_drain_a:
    assert property (@(posedge sys_clk_in) disable iff (reset_in)
        config_status_n_out == 1'b0 && config_complete_out == 1'b0) else $error("shared pin driven high");
    enable_after_own_a:
    assert property (@(posedge sys_clk_in) disable iff (reset_in) $fell(chain_enable_n_out) && !user_mode_out
        |-> $past(chain_enable_n_in, 3) == 1'b0) else $error("chain enabled without own load");
    lane_capture_a:
    assert property (@(posedge config_clock_in) disable iff (reset_in) config_byte_valid_out |-> config_byte_out
        == (hi_lane ? $past(flash_data_in[15:8]) : $past(flash_data_in[7:0]))) else $error("wrong byte lane");
    address_step_a:
    assert property (@(posedge config_clock_in) disable iff (reset_in)
        !flash_ce_n_out && flash_adv_n_out && $past(!flash_ce_n_out)
        |-> flash_addr_out == $past(flash_addr_out) + 24'h000001) else $error("address did not step");
endmodule // mdpcc_chain_monitor

bind mdpcc_chain_top mdpcc_chain_monitor u_mon (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .config_clock_in(config_clock_in),
    .scheme_select_pins_in(scheme_select_pins_in), .lane_high_strap_in(lane_high_strap_in),
    .chain_enable_n_in(chain_enable_n_in), .chain_enable_n_out(chain_enable_n_out),
    .config_complete_in(config_complete_in), .config_complete_out(config_complete_out),
    .config_complete_oe_out(config_complete_oe_out), .config_status_n_out(config_status_n_out),
    .init_start_out(init_start_out), .user_mode_out(user_mode_out), .user_wait_out(user_wait_out),
    .flash_data_in(flash_data_in), .flash_addr_out(flash_addr_out), .flash_ce_n_out(flash_ce_n_out),
    .flash_adv_n_out(flash_adv_n_out), .config_byte_out(config_byte_out),
    .config_byte_valid_out(config_byte_valid_out));

// [verif/mdpcc_flash_model.sv]
// Behavioural parallel flash answering synchronous reads on the configuration clock
module mdpcc_flash_model
    import mdpcc_pkg::*;
(
    input  wire logic              config_clock_in, // Shared configuration clock
    input  wire logic              ce_n_in,         // Chip enable, low active
    input  wire logic              oe_n_in,         // Output enable, low active
    input  wire logic [ADDR_W-1:0] addr_in,         // Word address
    output logic      [DATA_W-1:0] data_out         // Read data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial data_out = 16'h0000;
    // Low byte counts up and high byte down with the address; a deselected bus inverts every edge
    // so that a stale word can never pass for a fresh one
    always @(posedge config_clock_in) begin
        if (!ce_n_in && !oe_n_in) begin
            data_out <= {~addr_in[7:0], addr_in[7:0]};
        end else begin
            data_out <= ~data_out;
        end
    end
endmodule // mdpcc_flash_model

// [verif/mdpcc_chain_tb_top.sv]
// Self-checking bench for the daisy-chain configuration control
module mdpcc_chain_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mdpcc_pkg::*;
    localparam int IMG = 8;
    typedef struct packed { logic [1:0] scheme; logic hi; logic exp_run; logic exp_hi; } mdpcc_row_s;
    mdpcc_row_s rows [6] = '{'{2'h1, 1'b0, 1'b1, 1'b0}, '{2'h1, 1'b1, 1'b1, 1'b0}, '{2'h2, 1'b0, 1'b0, 1'b0},
                             '{2'h2, 1'b1, 1'b0, 1'b1}, '{2'h0, 1'b1, 1'b0, 1'b1}, '{2'h3, 1'b0, 1'b0, 1'b0}};
    logic                sys_clk_in = 1'b0, reset_in = 1'b1, cfg_clk = 1'b0, link_on = 1'b1;
    logic [SCHEME_W-1:0] scheme = 2'h1;
    logic                lane_hi = 1'b0, chain_in = 1'b1, uio_en = 1'b0, uio = 1'b0, reconf_n = 1'b1;
    logic                wait_in = 1'b0, other_low = 1'b1, abort = 1'b0, seen = 1'b0, saw_run = 1'b0;
    logic                chain_out, st_oe, cd_oe, run_out, init_pls, umode, uwait, ce_n, oe_n, bvalid, master;
    logic [ADDR_W-1:0]   addr, m_addr, first_addr, cnt = 24'h000000;
    logic [DATA_W-1:0]   bus;
    logic [BYTE_W-1:0]   bval;
    logic [BYTE_W-1:0]   bytes [64];
    int                  nb = 0, bad_count = 0, checks = 0;
    wire logic           st_w = !(st_oe || abort);     // Pull-up unless a party pulls low
    wire logic           cd_w = !(cd_oe || other_low); // other_low stands for a later device still loading
    assign master = (scheme == ACTIVE_PARALLEL_SCHEME);
    assign m_addr = master ? addr : cnt;

    always #25 sys_clk_in = ~sys_clk_in;
    // Link clock stands still between frames
    always #6 if (link_on) cfg_clk = ~cfg_clk;
    // Record captured bytes and the first address put out by a master
    always @(posedge cfg_clk) begin
        cnt <= cnt + 24'h000001;
        if (bvalid === 1'b1) begin
            bytes[nb[5:0]] <= bval;
            nb <= nb + 1;
        end
        if (ce_n === 1'b0 && !seen) begin
            first_addr <= addr;
            seen <= 1'b1;
        end
        if (run_out === 1'b1) saw_run <= 1'b1;
    end

    mdpcc_chain_top #(.IMAGE_BYTES(IMG)) dut (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .config_clock_in(cfg_clk), .scheme_select_pins_in(scheme),
        .lane_high_strap_in(lane_hi), .chain_enable_n_in(chain_in), .chain_enable_n_out(chain_out),
        .user_io_enable_in(uio_en), .user_io_in(uio), .reconfig_request_n_in(reconf_n), .config_status_n_in(st_w),
        .config_status_n_out(), .config_status_oe_out(st_oe), .config_complete_in(cd_w), .config_complete_out(),
        .config_complete_oe_out(cd_oe), .flash_addr_out(addr), .flash_data_in(bus), .flash_data_out(),
        .flash_data_oe_out(), .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n), .flash_adv_n_out(),
        .flash_we_n_out(), .flash_wait_in(wait_in), .user_wait_out(uwait), .config_byte_out(bval),
        .config_byte_valid_out(bvalid), .config_clock_run_out(run_out), .init_start_out(init_pls),
        .user_mode_out(umode));
    // Slaves see the same flash, addressed by a free-running count in place of the master
    mdpcc_flash_model flash (.config_clock_in(cfg_clk), .ce_n_in(master ? ce_n : 1'b0),
        .oe_n_in(master ? oe_n : 1'b0), .addr_in(m_addr), .data_out(bus));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    // Bounded wait: 0 for chain enable low, 1 for the init pulse
    task automatic wait_for(input int sel, input string what);
        int n;
        n = 0;
        while (!(sel == 0 ? chain_out === 1'b0 : init_pls === 1'b1)) begin
            cyc(1);
            n++;
            if (n > 2000) begin
                bad_count++;
                $display("wrong value %s expected event seen timeout", what);
                stop_test();
            end
        end
    endtask

    task automatic run_row(input mdpcc_row_s r);
        @(posedge sys_clk_in);
        reset_in <= 1'b1;
        scheme <= r.scheme;
        lane_hi <= r.hi;
        chain_in <= 1'b1;
        other_low <= 1'b1;
        wait_in <= 1'b1;
        uio_en <= 1'b0;
        link_on <= 1'b1;
        cyc(6);
        check("chain_enable_n_out", 1, chain_out);
        check("config_complete_oe_out", 1, cd_oe);
        nb = 0;
        seen = 1'b0;
        saw_run = 1'b0;
        @(posedge sys_clk_in);
        reset_in <= 1'b0;
        cyc(20);
        check("bytes while disabled", 0, nb);
        @(posedge sys_clk_in);
        chain_in <= 1'b0;
        wait_for(0, "chain_enable_n_out");
        cyc(2);
        check("byte count", IMG, nb);
        check("config_complete_oe_out", 0, cd_oe);
        check("clock run", r.exp_run, saw_run);
        check("user_wait_out", 0, uwait);
        if (r.exp_run) check("first address", BOOT_ADDR, first_addr);
        if (r.exp_run) check("first byte", BOOT_ADDR[7:0], bytes[0]);
        for (int i = 1; i < IMG; i++)
            check("byte step", 8'(bytes[i-1] + (r.exp_hi ? 8'hFF : 8'h01)), bytes[i]);
        cyc(20);
        check("user_mode_out while held", 0, umode);
        @(posedge sys_clk_in);
        other_low <= 1'b0;
        wait_for(1, "init_start_out");
        cyc(1);
        check("user_mode_out", 1, umode);
        cyc(4);
        check("user_wait_out", 1, uwait);
        repeat (30) @(posedge cfg_clk);
        @(posedge sys_clk_in);
        link_on <= 1'b0;
        $display("test row scheme %0h done", r.scheme);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        foreach (rows[i]) run_row(rows[i]);
        // Chain pin handed to user logic after configuration
        @(posedge sys_clk_in);
        uio_en <= 1'b1;
        uio <= 1'b1;
        cyc(2);
        check("chain_enable_n_out user", 1, chain_out);
        @(posedge sys_clk_in);
        uio <= 1'b0;
        cyc(2);
        check("chain_enable_n_out user", 0, chain_out);
        $display("test user pin done");
        // Reconfiguration request throws the device back; link stopped so the reload stalls
        @(posedge sys_clk_in);
        uio_en <= 1'b0;
        reconf_n <= 1'b0;
        other_low <= 1'b1;
        cyc(3);
        check("config_status_oe_out", 1, st_oe);
        @(posedge sys_clk_in);
        reconf_n <= 1'b1;
        cyc(8);
        check("user_mode_out", 0, umode);
        check("config_complete_oe_out", 1, cd_oe);
        // Status pulled low mid-load aborts, then a clean reload still completes
        @(posedge sys_clk_in);
        abort <= 1'b1;
        cyc(6);
        check("chain_enable_n_out abort", 1, chain_out);
        @(posedge sys_clk_in);
        abort <= 1'b0;
        link_on <= 1'b1;
        wait_for(0, "chain_enable_n_out");
        check("config_complete_oe_out", 0, cd_oe);
        $display("test reconfig and abort done");
        stop_test();
    end
endmodule // mdpcc_chain_tb_top
